/* logic/cqs_defs.svh */
`ifndef CQS_DEFS_SVH
`define CQS_DEFS_SVH

// width of every register in the group
`define CQS_REG_W 16
// condition bit positions for the two fallback-table flags
`define CQS_CH1_BIT 2
`define CQS_CH2_BIT 3
// summary position in the parent questionable condition word
`define CQS_QUEST_CAL_BIT 8
// reset value of masks and event latch
`define CQS_RST_VAL 16'h0000
// pin synchroniser depth
`define CQS_SYNC_STAGES 3

`endif

/* logic/cqs_pkg.sv */
package cqs_pkg;

    // register select codes of the command port
    typedef enum logic [2:0] {
        CQS_SEL_ENABLE = 3'h0,
        CQS_SEL_EVENT  = 3'h1,
        CQS_SEL_FALL   = 3'h2,
        CQS_SEL_RISE   = 3'h3,
        CQS_SEL_COND   = 3'h4
    } cqs_sel_t;

endpackage

/* logic/cqs_cond_sync.sv */
`timescale 1ns/1ns
`include "cqs_defs.svh"

module cqs_cond_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous levels in, filtered levels out
    input wire logic [W-1:0] raw_i,
    output logic [W-1:0] stable_o
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] stable_r;
    logic [W-1:0] stable_nxt;

    if (W < 1) begin : g_chk
        $error("cqs_cond_sync needs at least one bit");
    end

    // accept a change only once stages two and three agree,
    // so a level caught mid-flight never reaches the edge logic
    always_comb begin
        for (int i = 0; i < W; i++) begin
            stable_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : stable_r[i];
        end
    end

    // s1 feeds s2 only; nothing else looks at it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            stable_r <= '0;
        end else begin
            s1_r <= raw_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            stable_r <= stable_nxt;
        end
    end

    assign stable_o = stable_r;

endmodule

/* logic/cqs_status_group.sv */
`timescale 1ns/1ns
`include "cqs_defs.svh"

module cqs_status_group #(
    parameter int W = `CQS_REG_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // operating-state flags from the instrument
    input wire logic chan_one_fallback_table_i,
    input wire logic chan_two_fallback_table_i,
    // remote command port
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire cqs_pkg::cqs_sel_t cmd_sel_i,
    input wire logic [W-1:0] cmd_wdata_i,
    // command answer
    output logic rsp_valid_o,
    output logic rsp_error_o,
    output logic [W-1:0] rsp_data_o,
    // summary toward the parent group
    output logic cal_summary_o,
    output logic [W-1:0] quest_cond_o
);
    import cqs_pkg::*;

    if (W <= `CQS_QUEST_CAL_BIT) begin : g_chk
        $error("register width too small for the parent bit");
    end

    logic [1:0] flags_w;
    logic [W-1:0] cond_w;
    logic [W-1:0] prev_r;
    logic [W-1:0] en_r;
    logic [W-1:0] en_nxt;
    logic [W-1:0] fall_r;
    logic [W-1:0] fall_nxt;
    logic [W-1:0] rise_r;
    logic [W-1:0] rise_nxt;
    logic [W-1:0] ev_r;
    logic [W-1:0] ev_nxt;
    logic [W-1:0] edge_w;
    logic sum_r;
    logic sum_nxt;
    logic [W-1:0] pcond_r;
    logic [W-1:0] pcond_nxt;
    logic rsp_valid_r;
    logic rsp_valid_nxt;
    logic rsp_err_r;
    logic rsp_err_nxt;
    logic [W-1:0] rsp_data_r;
    logic [W-1:0] rsp_data_nxt;
    logic wr_w;
    logic rd_w;
    logic ev_clr_w;

    // flags come from another part of the instrument: synchronise
    cqs_cond_sync #(
        .W(2)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i({chan_two_fallback_table_i, chan_one_fallback_table_i}),
        .stable_o(flags_w)
    );

    // live condition word, unused bits tied low
    always_comb begin
        cond_w = '0;
        cond_w[`CQS_CH1_BIT] = flags_w[0];
        cond_w[`CQS_CH2_BIT] = flags_w[1];
    end

    // transition filters: prev_r is the condition one cycle back
    always_comb begin
        edge_w = (rise_r & cond_w & ~prev_r)
               | (fall_r & ~cond_w & prev_r);
    end

    assign wr_w = cmd_valid_i & cmd_write_i;
    assign rd_w = cmd_valid_i & ~cmd_write_i;
    assign ev_clr_w = rd_w & (cmd_sel_i == CQS_SEL_EVENT);

    // mask registers and event latch
    always_comb begin
        en_nxt = en_r;
        fall_nxt = fall_r;
        rise_nxt = rise_r;
        if (wr_w && cmd_sel_i == CQS_SEL_ENABLE) begin
            en_nxt = cmd_wdata_i;
        end else if (wr_w && cmd_sel_i == CQS_SEL_FALL) begin
            fall_nxt = cmd_wdata_i;
        end else if (wr_w && cmd_sel_i == CQS_SEL_RISE) begin
            rise_nxt = cmd_wdata_i;
        end
        // new edges are ORed after the clear so they survive it
        ev_nxt = (ev_clr_w ? '0 : ev_r) | edge_w;
        // summary from next values keeps it in step with the latch
        sum_nxt = |(ev_nxt & en_nxt);
        pcond_nxt = '0;
        pcond_nxt[`CQS_QUEST_CAL_BIT] = sum_nxt;
    end

    // command answer, one cycle after the request
    always_comb begin
        rsp_valid_nxt = cmd_valid_i;
        rsp_err_nxt = 1'b0;
        rsp_data_nxt = '0;
        if (wr_w) begin
            // event and condition are read only; unknown codes refused
            rsp_err_nxt = !(cmd_sel_i == CQS_SEL_ENABLE
                         || cmd_sel_i == CQS_SEL_FALL
                         || cmd_sel_i == CQS_SEL_RISE);
        end else if (rd_w) begin
            if (cmd_sel_i == CQS_SEL_ENABLE) begin
                rsp_data_nxt = en_r;
            end else if (cmd_sel_i == CQS_SEL_EVENT) begin
                rsp_data_nxt = ev_r;
            end else if (cmd_sel_i == CQS_SEL_FALL) begin
                rsp_data_nxt = fall_r;
            end else if (cmd_sel_i == CQS_SEL_RISE) begin
                rsp_data_nxt = rise_r;
            end else if (cmd_sel_i == CQS_SEL_COND) begin
                rsp_data_nxt = cond_w;
            end else begin
                rsp_err_nxt = 1'b1;
            end
        end
    end

    // registers of the group
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_r <= '0;
            en_r <= `CQS_RST_VAL;
            fall_r <= `CQS_RST_VAL;
            rise_r <= `CQS_RST_VAL;
            ev_r <= `CQS_RST_VAL;
            sum_r <= 1'b0;
            pcond_r <= '0;
            rsp_valid_r <= 1'b0;
            rsp_err_r <= 1'b0;
            rsp_data_r <= '0;
        end else begin
            prev_r <= cond_w;
            en_r <= en_nxt;
            fall_r <= fall_nxt;
            rise_r <= rise_nxt;
            ev_r <= ev_nxt;
            sum_r <= sum_nxt;
            pcond_r <= pcond_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_err_r <= rsp_err_nxt;
            rsp_data_r <= rsp_data_nxt;
        end
    end

    assign rsp_valid_o = rsp_valid_r;
    assign rsp_error_o = rsp_err_r;
    assign rsp_data_o = rsp_data_r;
    assign cal_summary_o = sum_r;
    assign quest_cond_o = pcond_r;

    // checks on the design's own outputs and state
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    mask_readback_a: assert property (
        wr_w && cmd_sel_i == CQS_SEL_ENABLE ##1
        rd_w && cmd_sel_i == CQS_SEL_ENABLE
        |=> rsp_data_o == $past(cmd_wdata_i, 2))
        else $error("enable mask readback wrong");

    summary_level_a: assert property (
        cal_summary_o == |(ev_r & en_r))
        else $error("summary does not match masked events");

    parent_bit_a: assert property (
        quest_cond_o[`CQS_QUEST_CAL_BIT] == cal_summary_o)
        else $error("parent bit differs from summary");

    parent_other_a: assert property (
        (quest_cond_o & ~(16'h0001 << `CQS_QUEST_CAL_BIT)) == '0)
        else $error("parent word has stray bits");

    event_clear_a: assert property (
        ev_clr_w && edge_w == '0
        |=> ev_r == '0 && rsp_data_o == $past(ev_r) && rsp_valid_o)
        else $error("event read did not return then clear");

    event_source_a: assert property (
        (ev_r & ~$past(ev_r)) == (ev_r & ~$past(ev_r) & $past(edge_w)))
        else $error("event bit set without filtered edge");

    fall_latch_a: assert property (
        (fall_r & prev_r & ~cond_w) != '0
        |=> (ev_r & $past(fall_r & prev_r & ~cond_w))
            == $past(fall_r & prev_r & ~cond_w))
        else $error("falling transition not latched");

    rise_latch_a: assert property (
        (rise_r & ~prev_r & cond_w) != '0
        |=> (ev_r & $past(rise_r & ~prev_r & cond_w))
            == $past(rise_r & ~prev_r & cond_w))
        else $error("rising transition not latched");

    filter_write_a: assert property (
        wr_w && cmd_sel_i == CQS_SEL_RISE
        |=> rise_r == $past(cmd_wdata_i) && fall_r == $past(fall_r))
        else $error("rising filter write wrong");

    cond_map_a: assert property (
        rd_w && cmd_sel_i == CQS_SEL_COND
        |=> (rsp_data_o & ~16'h000c) == '0)
        else $error("unused condition bits not zero");

    cond_track_a: assert property (
        $stable(chan_one_fallback_table_i) [*5]
        |-> cond_w[`CQS_CH1_BIT] == chan_one_fallback_table_i)
        else $error("condition does not follow flag");

    clear_race_a: assert property (
        ev_clr_w && edge_w != '0 |=> ev_r == $past(edge_w))
        else $error("event lost during clearing read");

    reset_zero_a: assert property (
        $past(rst_i) |-> en_r == '0 && ev_r == '0
            && rise_r == '0 && fall_r == '0)
        else $error("registers not zero after reset");

    // main scenarios
    rise_seen_c: cover property ((rise_r & ~prev_r & cond_w) != '0);
    fall_seen_c: cover property ((fall_r & prev_r & ~cond_w) != '0);
    summary_c: cover property (!cal_summary_o ##1 cal_summary_o);
    race_c: cover property (ev_clr_w && edge_w != '0);

endmodule

/* verification/cqs_status_group_bench.sv */
`timescale 1ns/1ns
module cqs_status_group_bench;
    import cqs_pkg::*;
    // stimulus, bench model of masks, events and condition
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pin_one = 1'b0;
    logic pin_two = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic cmd_write_i = 1'b0;
    cqs_sel_t cmd_sel_i = CQS_SEL_ENABLE;
    logic [15:0] cmd_wdata_i = 16'h0000;
    logic rsp_valid_o, rsp_error_o, cal_summary_o, err;
    logic [15:0] rsp_data_o, quest_cond_o, rd, first;
    logic [15:0] en_m, rise_m, fall_m, ev_m;
    logic [1:0] cond_m;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 74899;
    int i, d;

    cqs_status_group uut (
        .clk_i(clk_i), .rst_i(rst_i),
        .chan_one_fallback_table_i(pin_one),
        .chan_two_fallback_table_i(pin_two),
        .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
        .cmd_sel_i(cmd_sel_i), .cmd_wdata_i(cmd_wdata_i),
        .rsp_valid_o(rsp_valid_o), .rsp_error_o(rsp_error_o),
        .rsp_data_o(rsp_data_o), .cal_summary_o(cal_summary_o),
        .quest_cond_o(quest_cond_o)
    );

    // 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // hang guard, generous against the roughly 1000 cycles of the run
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            test_done;
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // expected event bits from one condition change
    function automatic logic [15:0] edge_ev(input logic [1:0] o,
        input logic [1:0] n, input logic [15:0] r, input logic [15:0] f);
        logic [15:0] ov;
        logic [15:0] nv;
        ov = {12'h000, o, 2'b00};
        nv = {12'h000, n, 2'b00};
        return (r & ~ov & nv) | (f & ov & ~nv);
    endfunction

    // one command; valid held one edge, answer taken the cycle after
    task automatic cmd(input logic wr, input logic [2:0] sel,
        input logic [15:0] data);
        @(posedge clk_i);
        #1;
        cmd_valid_i = 1'b1;
        cmd_write_i = wr;
        cmd_sel_i = cqs_sel_t'(sel);
        cmd_wdata_i = data;
        @(posedge clk_i);
        #1;
        cmd_valid_i = 1'b0;
        check({15'h0000, rsp_valid_o}, 16'h0001);
        err = rsp_error_o;
        rd = rsp_data_o;
    endtask

    task automatic wr_ok(input logic [2:0] sel, input logic [15:0] data);
        cmd(1'b1, sel, data);
        check({15'h0000, err}, 16'h0000);
    endtask

    task automatic rd_chk(input logic [2:0] sel, input logic [15:0] exp);
        cmd(1'b0, sel, 16'h0000);
        check({15'h0000, err}, 16'h0000);
        check(rd, exp);
    endtask

    task automatic set_pins(input logic [1:0] p);
        @(posedge clk_i);
        #1;
        ev_m = ev_m | edge_ev(cond_m, p, rise_m, fall_m);
        cond_m = p;
        pin_one = p[0];
        pin_two = p[1];
    endtask

    task automatic sum_chk;
        check({15'h0000, cal_summary_o}, {15'h0000, |(ev_m & en_m)});
        check(quest_cond_o, {7'h00, |(ev_m & en_m), 8'h00});
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        en_m = 16'h0000;
        rise_m = 16'h0000;
        fall_m = 16'h0000;
        ev_m = 16'h0000;
        cond_m = 2'b00;
        rd_chk(CQS_SEL_ENABLE, 16'h0000);
        rd_chk(CQS_SEL_FALL, 16'h0000);
        rd_chk(CQS_SEL_RISE, 16'h0000);
        rd_chk(CQS_SEL_EVENT, 16'h0000);
        wr_ok(CQS_SEL_ENABLE, 16'hffff);
        // refused selects must not touch any state
        for (i = 1; i < 8; i++) begin
            if (i != 2 && i != 3) begin
                cmd(1'b1, 3'(i), 16'h1234);
                check({15'h0000, err}, 16'h0001);
                if (i > 4) begin
                    cmd(1'b0, 3'(i), 16'h0000);
                    check({15'h0000, err}, 16'h0001);
                end
            end
        end
        rd_chk(CQS_SEL_ENABLE, 16'hffff);
        rd_chk(CQS_SEL_EVENT, 16'h0000);
        // back-to-back write then read of the enable mask, no idle cycle
        @(posedge clk_i);
        #1;
        cmd_valid_i = 1'b1;
        cmd_write_i = 1'b1;
        cmd_sel_i = CQS_SEL_ENABLE;
        cmd_wdata_i = 16'h5a3c;
        @(posedge clk_i);
        #1;
        cmd_write_i = 1'b0;
        check({15'h0000, rsp_valid_o}, 16'h0001);
        @(posedge clk_i);
        #1;
        cmd_valid_i = 1'b0;
        check({15'h0000, rsp_valid_o}, 16'h0001);
        check(rsp_data_o, 16'h5a3c);
        // the answer stands one cycle only
        @(posedge clk_i);
        #1;
        check({15'h0000, rsp_valid_o}, 16'h0000);
        // random masks and pin moves, enable and rising-mask corners first
        for (i = 0; i < 30; i++) begin
            en_m = (i < 2) ? {16{i[0]}} : 16'($random(seed));
            rise_m = (i < 2) ? {16{i[0]}} : 16'($random(seed));
            fall_m = 16'($random(seed));
            wr_ok(CQS_SEL_ENABLE, en_m);
            wr_ok(CQS_SEL_RISE, rise_m);
            wr_ok(CQS_SEL_FALL, fall_m);
            rd_chk(CQS_SEL_ENABLE, en_m);
            rd_chk(CQS_SEL_RISE, rise_m);
            rd_chk(CQS_SEL_FALL, fall_m);
            set_pins(2'($random(seed)));
            repeat (7) @(posedge clk_i);
            #1;
            sum_chk;
            rd_chk(CQS_SEL_COND, {12'h000, cond_m, 2'b00});
            rd_chk(CQS_SEL_EVENT, ev_m);
            ev_m = 16'h0000;
            sum_chk;
            rd_chk(CQS_SEL_EVENT, 16'h0000);
        end
        // sweep a clearing read across the moment an edge lands
        rise_m = 16'hffff;
        fall_m = 16'hffff;
        wr_ok(CQS_SEL_RISE, rise_m);
        wr_ok(CQS_SEL_FALL, fall_m);
        for (d = 0; d < 8; d++) begin
            set_pins(~cond_m);
            repeat (d) @(posedge clk_i);
            cmd(1'b0, CQS_SEL_EVENT, 16'h0000);
            first = rd;
            repeat (8) @(posedge clk_i);
            cmd(1'b0, CQS_SEL_EVENT, 16'h0000);
            check(first | rd, 16'h000c);
            check(first & rd, 16'h0000);
        end
        test_done;
    end
endmodule
